// [verilog/width_cfg_pkg.sv]
package width_cfg_pkg;

   // Data and address widths of the two PCI interfaces
   localparam int WIDE_DATA_W   = 64;
   localparam int NARROW_DATA_W = 32;
   localparam int PCI_ADDR_W    = 32;
   localparam int EXT_AD_W      = WIDE_DATA_W - NARROW_DATA_W;
   localparam int EXT_BE_W      = 4;

   // Register byte offsets
   localparam logic [31:0] STATUS_OFS  = 32'h0000_0000;
   localparam logic [31:0] CONTROL_OFS = 32'h0000_0004;

   // Status field positions
   localparam int ST_WIDE_64     = 0;
   localparam int ST_WIDTH_VALID = 1;
   localparam int ST_HOST_DRIVE  = 2;
   localparam int ST_PRIMARY     = 3;
   localparam int ST_FAST_CAP    = 4;
   localparam int ST_WIDE_SPEED  = 5;
   localparam int ST_NARROW_SPD  = 6;
   localparam int ST_HOT_SWAP    = 7;
   localparam int ST_NEW_WIDTH   = 8;

   // Control field positions
   localparam int CT_CLR_NEW = 0;

   // Reset values
   localparam logic [31:0] STATUS_RST = 32'h0000_0010;
   localparam logic        READY_RST  = 1'b1;
   localparam logic        FLAG_RST   = 1'b0;

   // Constant drive level of the 64-bit extension pins
   localparam logic [EXT_AD_W-1:0] EXT_AD_LOW = '0;
   localparam logic [EXT_BE_W-1:0] EXT_BE_LOW = '0;

   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // Power-up option bundle
   typedef struct packed {
      logic hot_swap;
      logic host_width_drive_option;
      logic primary_bus_select_option;
      logic wide_bus_speed_enable;
      logic narrow_bus_speed_enable;
   } pwrup_s;

   // Link pins sampled on the wide bus clock
   typedef struct packed {
      logic pci_rst_n;
      logic req64_n;
      logic wide_width_strap_n;
      logic hot_swap;
      logic host_width_drive_option;
   } link_pins_s;

   // Width result passed to the register clock
   typedef struct packed {
      logic wide_64;
      logic valid;
      logic cap_toggle;
   } width_s;

endpackage

// [verilog/pci_width_primary_config.sv]
// Summary of operation
// - Non hot-swap: 64-bit if REQ64 or strap low, else 32-bit.
// - Hot-swap: strap alone sets width; low is 64-bit, open 32-bit.
// - Host option with low strap, outside hot-swap, drives REQ64 low in reset; status bit.
// - 32-bit mode drives upper AD, byte enables, REQ64, ACK64, PAR64 low.
// - Wide port: 64-bit data, 32-bit address; second: 32-bit both.
// - Power-up strap sets primary port; status bit only reports it.
// - Single-interface variant reads primary status bit as 0.
// - Each port clocked 25 to 66 MHz; speed pin sampled at power-up.
// - Ports run asynchronously to each other; all paths cross.
// - Fast-capable flag always reads as set.
// - No ordering between one source's transactions to different ports.
// - Internal DMA and interrupt events unordered against external ones.
`timescale 1ns/10ps
`default_nettype none
module pci_width_primary_config
   import width_cfg_pkg::*;
#(
   parameter bit DUAL_VARIANT = 1'b1
) (
   // Register clock and reset
   input  wire logic                 ref_clk_i,
   input  wire logic                 rst_i,
   // Wide bus link clock and pins
   input  wire logic                 pci1_clk_i,
   input  wire logic                 pci1_rst_n_i,
   input  wire logic                 req64_n_i,
   input  wire logic                 wide_width_strap_n_i,
   // Power-up option pins
   input  wire logic                 hot_swap_i,
   input  wire logic                 host_width_drive_option_i,
   input  wire logic                 primary_bus_select_option_i,
   input  wire logic                 wide_bus_speed_enable_i,
   input  wire logic                 narrow_bus_speed_enable_i,
   // 64-bit extension pin drivers
   output logic [EXT_AD_W-1:0]       ad_hi_o,
   output logic                      ad_hi_oe_o,
   output logic [EXT_BE_W-1:0]       cbe_hi_n_o,
   output logic                      cbe_hi_oe_o,
   output logic                      req64_n_o,
   output logic                      req64_n_oe_o,
   output logic                      ack64_n_o,
   output logic                      ack64_n_oe_o,
   output logic                      par64_o,
   output logic                      par64_oe_o,
   // AXI4-Lite write channels
   input  wire logic [31:0]          s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   output logic [1:0]                s_axi_bresp,
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   // AXI4-Lite read channels
   input  wire logic [31:0]          s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   output logic [31:0]               s_axi_rdata,
   output logic [1:0]                s_axi_rresp,
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready
);

   // ---------------- Link domain (wide bus clock) ----------------
   link_pins_s link_s1_ff;
   link_pins_s link_s2_ff;
   logic       lrst_s1_ff;
   logic       lrst_s2_ff;
   logic       prst_d_ff;
   logic       width_64_ff;
   logic       width_valid_ff;
   logic       cap_tgl_ff;
   logic       req64_oe_ff;
   logic       ext_oe_ff;
   logic       negation;
   logic       nxt_req64_oe;
   logic       lrst_ack_ff;
   logic       lrst_req_ff;
   logic       lack_s1_ff;
   logic       lack_s2_ff;

   // Every link pin and the register-side reset pass two flops here
   always_ff @(posedge pci1_clk_i) begin
      link_s1_ff <= '{pci_rst_n:               pci1_rst_n_i,
                      req64_n:                 req64_n_i,
                      wide_width_strap_n:      wide_width_strap_n_i,
                      hot_swap:                hot_swap_i,
                      host_width_drive_option: host_width_drive_option_i};
      link_s2_ff <= link_s1_ff;
      lrst_s1_ff  <= lrst_req_ff;
      lrst_s2_ff  <= lrst_s1_ff;
      lrst_ack_ff <= lrst_s2_ff;
   end

   always_ff @(posedge pci1_clk_i) begin
      if (lrst_s2_ff) begin
         prst_d_ff <= 1'b1;
      end else begin
         prst_d_ff <= link_s2_ff.pci_rst_n;
      end
   end

   assign negation = link_s2_ff.pci_rst_n && !prst_d_ff;

   // Width is decided once per reset and only from the wide bus pins,
   // so nothing here waits on traffic of any other interface
   always_ff @(posedge pci1_clk_i) begin
      if (lrst_s2_ff) begin
         width_64_ff <= FLAG_RST;
         cap_tgl_ff  <= FLAG_RST;
      end else if (negation) begin
         cap_tgl_ff <= !cap_tgl_ff;
         if (link_s2_ff.hot_swap) begin
            width_64_ff <= !link_s2_ff.wide_width_strap_n;
         end else begin
            width_64_ff <= !(link_s2_ff.req64_n &&
                             link_s2_ff.wide_width_strap_n);
         end
      end
   end

   always_ff @(posedge pci1_clk_i) begin
      if (lrst_s2_ff) begin
         width_valid_ff <= FLAG_RST;
      end else if (!link_s2_ff.pci_rst_n) begin
         width_valid_ff <= 1'b0;
      end else if (negation) begin
         width_valid_ff <= 1'b1;
      end
   end

   // Safe only when this device also owns the PCI reset
   always_comb begin
      nxt_req64_oe = !link_s2_ff.pci_rst_n &&
                     link_s2_ff.host_width_drive_option &&
                     !link_s2_ff.wide_width_strap_n &&
                     !link_s2_ff.hot_swap;
   end

   always_ff @(posedge pci1_clk_i) begin
      if (lrst_s2_ff) begin
         req64_oe_ff <= FLAG_RST;
         ext_oe_ff   <= FLAG_RST;
      end else begin
         ext_oe_ff   <= width_valid_ff && !width_64_ff;
         req64_oe_ff <= nxt_req64_oe ||
                        (width_valid_ff && !width_64_ff);
      end
   end

   // Parked extension pins stop floating inputs burning power
   assign ad_hi_o      = EXT_AD_LOW;
   assign cbe_hi_n_o   = EXT_BE_LOW;
   assign req64_n_o    = 1'b0;
   assign ack64_n_o    = 1'b0;
   assign par64_o      = 1'b0;
   assign ad_hi_oe_o   = ext_oe_ff;
   assign cbe_hi_oe_o  = ext_oe_ff;
   assign ack64_n_oe_o = ext_oe_ff;
   assign par64_oe_o   = ext_oe_ff;
   assign req64_n_oe_o = req64_oe_ff;

   // ---------------- Register domain ----------------
   width_s  wsync1_ff;
   width_s  wsync2_ff;
   logic    tgl_d_ff;
   pwrup_s  pw_s1_ff;
   pwrup_s  pw_s2_ff;
   pwrup_s  pw_cap_ff;
   logic    pw_done_ff;
   logic    new_width_ff;
   logic    width_event;
   logic    clr_new;
   logic [31:0] status_w;

   always_ff @(posedge ref_clk_i) begin
      wsync1_ff <= '{wide_64:    width_64_ff,
                     valid:      width_valid_ff,
                     cap_toggle: cap_tgl_ff};
      wsync2_ff <= wsync1_ff;
      pw_s1_ff  <= '{hot_swap:                  hot_swap_i,
                     host_width_drive_option:   host_width_drive_option_i,
                     primary_bus_select_option: primary_bus_select_option_i,
                     wide_bus_speed_enable:     wide_bus_speed_enable_i,
                     narrow_bus_speed_enable:   narrow_bus_speed_enable_i};
      pw_s2_ff  <= pw_s1_ff;
      lack_s1_ff <= lrst_ack_ff;
      lack_s2_ff <= lack_s1_ff;
   end

   // Held until the bus side answers: a short pulse can slip between
   // two edges of the much slower bus clock
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         lrst_req_ff <= 1'b1;
      end else if (lack_s2_ff) begin
         lrst_req_ff <= 1'b0;
      end
   end

   // Power-up options are caught once, on the first edge after release
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         pw_cap_ff  <= '0;
         pw_done_ff <= FLAG_RST;
      end else if (!pw_done_ff) begin
         pw_cap_ff  <= pw_s2_ff;
         pw_done_ff <= 1'b1;
      end
   end

   // No reset: it tracks the bus side until that side's reset has landed
   always_ff @(posedge ref_clk_i) begin
      tgl_d_ff <= wsync2_ff.cap_toggle;
   end

   assign width_event = wsync2_ff.cap_toggle != tgl_d_ff;

   // A new capture landing with the clear still leaves the flag set
   always_ff @(posedge ref_clk_i) begin
      if (rst_i || lrst_req_ff) begin
         new_width_ff <= FLAG_RST;
      end else if (width_event) begin
         new_width_ff <= 1'b1;
      end else if (clr_new) begin
         new_width_ff <= 1'b0;
      end
   end

   always_comb begin
      status_w                 = STATUS_RST;
      status_w[ST_WIDE_64]     = wsync2_ff.wide_64;
      status_w[ST_WIDTH_VALID] = wsync2_ff.valid;
      status_w[ST_HOST_DRIVE]  = pw_cap_ff.host_width_drive_option;
      status_w[ST_PRIMARY]     = DUAL_VARIANT &&
                                 pw_cap_ff.primary_bus_select_option;
      status_w[ST_FAST_CAP]    = 1'b1;
      status_w[ST_WIDE_SPEED]  = pw_cap_ff.wide_bus_speed_enable;
      status_w[ST_NARROW_SPD]  = DUAL_VARIANT &&
                                 pw_cap_ff.narrow_bus_speed_enable;
      status_w[ST_HOT_SWAP]    = pw_cap_ff.hot_swap;
      status_w[ST_NEW_WIDTH]   = new_width_ff;
   end

   // ---------------- AXI4-Lite slave ----------------
   logic        awready_ff;
   logic        wready_ff;
   logic        aw_got_ff;
   logic        w_got_ff;
   logic [31:0] waddr_ff;
   logic [31:0] wdata_ff;
   logic [3:0]  wstrb_ff;
   logic        bvalid_ff;
   logic [1:0]  bresp_ff;
   logic        arready_ff;
   logic        rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0]  rresp_ff;
   logic        wr_fire;

   function automatic logic is_mapped(input logic [31:0] addr);
      is_mapped = (addr == STATUS_OFS) || (addr == CONTROL_OFS);
   endfunction

   assign wr_fire = aw_got_ff && w_got_ff && !bvalid_ff;
   assign clr_new = wr_fire && (waddr_ff == CONTROL_OFS) &&
                    wstrb_ff[0] && wdata_ff[CT_CLR_NEW];

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         awready_ff <= READY_RST;
         aw_got_ff  <= FLAG_RST;
         waddr_ff   <= '0;
      end else if (s_axi_bvalid && s_axi_bready) begin
         awready_ff <= 1'b1;
         aw_got_ff  <= 1'b0;
      end else if (s_axi_awvalid && awready_ff) begin
         awready_ff <= 1'b0;
         aw_got_ff  <= 1'b1;
         waddr_ff   <= {s_axi_awaddr[31:2], 2'b00};
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         wready_ff <= READY_RST;
         w_got_ff  <= FLAG_RST;
         wdata_ff  <= '0;
         wstrb_ff  <= '0;
      end else if (s_axi_bvalid && s_axi_bready) begin
         wready_ff <= 1'b1;
         w_got_ff  <= 1'b0;
      end else if (s_axi_wvalid && wready_ff) begin
         wready_ff <= 1'b0;
         w_got_ff  <= 1'b1;
         wdata_ff  <= s_axi_wdata;
         wstrb_ff  <= s_axi_wstrb;
      end
   end

   // Writes to status are accepted and dropped
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         bvalid_ff <= FLAG_RST;
         bresp_ff  <= RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_ff <= 1'b1;
         bresp_ff  <= is_mapped(waddr_ff) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_ff <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         arready_ff <= READY_RST;
         rvalid_ff  <= FLAG_RST;
         rdata_ff   <= '0;
         rresp_ff   <= RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
         arready_ff <= 1'b1;
         rvalid_ff  <= 1'b0;
      end else if (s_axi_arvalid && arready_ff) begin
         arready_ff <= 1'b0;
         rvalid_ff  <= 1'b1;
         rresp_ff   <= is_mapped({s_axi_araddr[31:2], 2'b00}) ?
                       RESP_OKAY : RESP_SLVERR;
         rdata_ff   <= (s_axi_araddr[31:2] == STATUS_OFS[31:2]) ?
                       status_w : '0;
      end
   end

   assign s_axi_awready = awready_ff;
   assign s_axi_wready  = wready_ff;
   assign s_axi_bvalid  = bvalid_ff;
   assign s_axi_bresp   = bresp_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_rvalid  = rvalid_ff;
   assign s_axi_rdata   = rdata_ff;
   assign s_axi_rresp   = rresp_ff;

   // ---------------- Checks ----------------
   sequence pci_negation_seq;
      link_s2_ff.pci_rst_n && !prst_d_ff;
   endsequence

   a_width_wide_pick: assert property (
      @(posedge pci1_clk_i) disable iff (lrst_s2_ff)
      pci_negation_seq and !link_s2_ff.hot_swap &&
      !(link_s2_ff.req64_n && link_s2_ff.wide_width_strap_n)
      |=> width_64_ff && width_valid_ff)
      else $error("wide width not chosen");

   a_width_narrow_pick: assert property (
      @(posedge pci1_clk_i) disable iff (lrst_s2_ff)
      pci_negation_seq and !link_s2_ff.hot_swap &&
      link_s2_ff.req64_n && link_s2_ff.wide_width_strap_n
      |=> !width_64_ff ##1 ext_oe_ff)
      else $error("narrow width not chosen or not parked");

   a_hot_swap_width: assert property (
      @(posedge pci1_clk_i) disable iff (lrst_s2_ff)
      pci_negation_seq and link_s2_ff.hot_swap
      |=> width_64_ff == !$past(link_s2_ff.wide_width_strap_n))
      else $error("hot swap width not from strap");

   a_req64_reset_drive: assert property (
      @(posedge pci1_clk_i) disable iff (lrst_s2_ff)
      !link_s2_ff.pci_rst_n && link_s2_ff.host_width_drive_option &&
      !link_s2_ff.wide_width_strap_n && !link_s2_ff.hot_swap
      |=> req64_n_oe_o && !req64_n_o)
      else $error("REQ64 not driven low in reset");

   a_ext_pins_low: assert property (
      @(posedge pci1_clk_i) disable iff (lrst_s2_ff)
      width_valid_ff && !width_64_ff
      |=> ad_hi_oe_o && cbe_hi_oe_o && ack64_n_oe_o && par64_oe_o &&
          req64_n_oe_o && ad_hi_o == EXT_AD_LOW)
      else $error("extension pins not parked low");

   a_width_hold: assert property (
      @(posedge pci1_clk_i) disable iff (lrst_s2_ff)
      width_valid_ff && link_s2_ff.pci_rst_n |=> $stable(width_64_ff))
      else $error("width changed outside reset");

   a_primary_stable: assert property (
      @(posedge ref_clk_i) disable iff (rst_i)
      pw_done_ff ##1 s_axi_bvalid |-> $stable(pw_cap_ff))
      else $error("primary choice changed after power-up");

   a_fast_flag_read: assert property (
      @(posedge ref_clk_i) disable iff (rst_i)
      $rose(s_axi_rvalid) && $past(s_axi_araddr) == STATUS_OFS
      |-> s_axi_rdata[ST_FAST_CAP] && s_axi_rresp == RESP_OKAY)
      else $error("fast capable flag not set");

   a_single_primary: assert property (
      @(posedge ref_clk_i) disable iff (rst_i)
      !DUAL_VARIANT && s_axi_rvalid |-> !s_axi_rdata[ST_PRIMARY])
      else $error("primary bit set in single variant");

   a_new_width_set: assert property (
      @(posedge ref_clk_i) disable iff (rst_i || lrst_req_ff)
      width_event |=> new_width_ff)
      else $error("capture event lost");

endmodule
`default_nettype wire

// [sim/pci_far_side.sv]
`timescale 1ns/10ps
`default_nettype none
// Central resource and other agent on the wide bus
module pci_far_side (
   // Wide bus clock and bench requests
   input  wire logic pci_clk_i,
   input  wire logic rst_req_i,
   input  wire logic agent_req64_n_i,
   input  wire logic strap_open_i,
   // Device drive of the REQ64 line
   input  wire logic dev_req64_n_i,
   input  wire logic dev_req64_oe_i,
   // Resolved lines
   output logic      pci_rst_n_o,
   output logic      req64_n_o,
   output logic      strap_n_o
);
   // Reset retimed to the bus clock, as a central resource would drive it
   always_ff @(posedge pci_clk_i) begin
      pci_rst_n_o <= ~rst_req_i;
   end
   // Device drive wins over the agent on the shared line
   assign req64_n_o = dev_req64_oe_i ? dev_req64_n_i : agent_req64_n_i;
   // Open strap floats to the board pull-up
   assign strap_n_o = strap_open_i ? 1'b1 : 1'b0;
endmodule
`default_nettype wire

// [sim/tb_pci_width_primary_config.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_pci_width_primary_config;
   import width_cfg_pkg::*;
   logic ref_clk_i, rst_i, pci1_clk_i, pci1_rst_n_i, req64_n_i;
   logic wide_width_strap_n_i, hot_swap_i, host_width_drive_option_i;
   logic primary_bus_select_option_i, wide_bus_speed_enable_i;
   logic narrow_bus_speed_enable_i, ad_hi_oe_o, cbe_hi_oe_o, req64_n_o;
   logic req64_n_oe_o, ack64_n_o, ack64_n_oe_o, par64_o, par64_oe_o;
   logic [EXT_AD_W-1:0] ad_hi_o;
   logic [EXT_BE_W-1:0] cbe_hi_n_o;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready, rst_req, areq, sopen;
   int   err_total, checked, seed;
   logic [31:0] single_rdata;
   pci_width_primary_config u_dut (.ref_clk_i, .rst_i, .pci1_clk_i,
      .pci1_rst_n_i, .req64_n_i, .wide_width_strap_n_i, .hot_swap_i,
      .host_width_drive_option_i, .primary_bus_select_option_i,
      .wide_bus_speed_enable_i, .narrow_bus_speed_enable_i, .ad_hi_o,
      .ad_hi_oe_o, .cbe_hi_n_o, .cbe_hi_oe_o, .req64_n_o, .req64_n_oe_o,
      .ack64_n_o, .ack64_n_oe_o, .par64_o, .par64_oe_o, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   pci_far_side u_far (.pci_clk_i(pci1_clk_i), .rst_req_i(rst_req),
      .agent_req64_n_i(areq), .strap_open_i(sopen),
      .dev_req64_n_i(req64_n_o), .dev_req64_oe_i(req64_n_oe_o),
      .pci_rst_n_o(pci1_rst_n_i), .req64_n_o(req64_n_i),
      .strap_n_o(wide_width_strap_n_i));
   // Single-interface variant, read alongside on the same bus requests
   pci_width_primary_config #(.DUAL_VARIANT(1'b0)) u_single (.ref_clk_i,
      .rst_i, .pci1_clk_i, .pci1_rst_n_i, .req64_n_i, .wide_width_strap_n_i,
      .hot_swap_i, .host_width_drive_option_i, .primary_bus_select_option_i,
      .wide_bus_speed_enable_i, .narrow_bus_speed_enable_i, .ad_hi_o(),
      .ad_hi_oe_o(), .cbe_hi_n_o(), .cbe_hi_oe_o(), .req64_n_o(),
      .req64_n_oe_o(), .ack64_n_o(), .ack64_n_oe_o(), .par64_o(),
      .par64_oe_o(), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready(),
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready(),
      .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready(), .s_axi_rdata(single_rdata),
      .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready);
   initial begin
      ref_clk_i = 1'b0;
      forever #2.5 ref_clk_i = ~ref_clk_i;
   end
   // Bus clock runs free, phase unrelated to the register clock
   initial begin
      pci1_clk_i = 1'b0;
      #37;
      forever #80 pci1_clk_i = ~pci1_clk_i;
   end
   task automatic final_report();
      if (err_total == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         err_total++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic chk_pin(input logic g, input logic e);
      chk_reg({31'h0, g}, {31'h0, e});
   endtask
   task automatic axi_wr(input logic [31:0] a, input logic [31:0] d,
                         output logic [1:0] r);
      @(posedge ref_clk_i);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      for (int n = 0; n < 100; n++) begin
         @(posedge ref_clk_i);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) begin
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
            return;
         end
      end
      err_total++;
      final_report();
   endtask
   task automatic axi_rd(input logic [31:0] a, output logic [31:0] d,
                         output logic [1:0] r);
      @(posedge ref_clk_i);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      for (int n = 0; n < 100; n++) begin
         @(posedge ref_clk_i);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) begin
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
            return;
         end
      end
      err_total++;
      final_report();
   endtask
   initial begin
      logic [31:0] d, e;
      logic [1:0]  r;
      logic [2:0]  c;
      logic        host, prim, wsp, nsp, drv, w64;
      err_total = 0;
      checked = 0;
      seed = 91;
      rst_i = 1'b1;
      rst_req = 1'b1;
      {areq, sopen, hot_swap_i} = 3'b110;
      {host_width_drive_option_i, primary_bus_select_option_i} = 2'b00;
      {wide_bus_speed_enable_i, narrow_bus_speed_enable_i} = 2'b00;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
      {s_axi_arvalid, s_axi_rready} = 2'b00;
      s_axi_awaddr = 32'h0000_0000;
      s_axi_araddr = 32'h0000_0000;
      s_axi_wdata = 32'h0000_0000;
      s_axi_wstrb = 4'hf;
      for (int p = 0; p < 2; p++) begin
         host = (p == 0);
         prim = p[0];
         {wsp, nsp} = 2'($random(seed));
         @(posedge ref_clk_i);
         rst_i <= 1'b1;
         host_width_drive_option_i <= host;
         primary_bus_select_option_i <= prim;
         wide_bus_speed_enable_i <= wsp;
         narrow_bus_speed_enable_i <= nsp;
         repeat (16) @(posedge ref_clk_i);
         rst_i <= 1'b0;
         for (int i = 0; i < 12; i++) begin
            c = (i < 8) ? 3'(i) : 3'($random(seed));
            @(posedge ref_clk_i);
            {hot_swap_i, areq, sopen} <= c;
            rst_req <= 1'b1;
            repeat (6) @(posedge pci1_clk_i);
            @(posedge ref_clk_i);
            drv = host && !c[0] && !c[2];
            chk_pin(req64_n_oe_o, drv);
            chk_pin(ad_hi_oe_o, 1'b0);
            w64 = c[2] ? !c[0] : !((drv ? 1'b0 : c[1]) && c[0]);
            rst_req <= 1'b0;
            repeat (8) @(posedge pci1_clk_i);
            // Pin changes after negation must not move the width
            @(posedge ref_clk_i);
            {hot_swap_i, areq, sopen} <= ~c;
            repeat (4) @(posedge pci1_clk_i);
            e = {23'h0, 1'b1, 1'b0, nsp, wsp, 1'b1, prim, host, 1'b1, w64};
            axi_rd(STATUS_OFS, d, r);
            chk_reg(d & ~32'h0000_0080, e);
            chk_reg({30'h0, r}, {30'h0, RESP_OKAY});
            chk_pin(single_rdata[ST_PRIMARY], 1'b0);
            chk_reg({27'h0, ad_hi_oe_o, cbe_hi_oe_o, req64_n_oe_o,
                     ack64_n_oe_o, par64_oe_o},
                    w64 ? 32'h0000_0000 : 32'h0000_001f);
            chk_reg(ad_hi_o, 32'h0000_0000);
            chk_reg({25'h0, cbe_hi_n_o, req64_n_o, ack64_n_o, par64_o},
                    32'h0000_0000);
            axi_wr(CONTROL_OFS, 32'h0000_0001, r);
            chk_reg({30'h0, r}, {30'h0, RESP_OKAY});
            axi_rd(STATUS_OFS, d, r);
            chk_reg(d & ~32'h0000_0080, e & ~32'h0000_0100);
         end
         // Status is read-only: a write must leave the reported choice alone
         axi_wr(STATUS_OFS, 32'hffff_ffff, r);
         chk_reg({30'h0, r}, {30'h0, RESP_OKAY});
         axi_rd(STATUS_OFS, d, r);
         chk_reg(d & ~32'h0000_0080, e & ~32'h0000_0100);
         axi_rd(CONTROL_OFS, d, r);
         chk_reg(d, 32'h0000_0000);
         axi_wr(32'h0000_0010, 32'h0000_0001, r);
         chk_reg({30'h0, r}, {30'h0, RESP_SLVERR});
         axi_rd(32'h0000_0010, d, r);
         chk_reg({r, d[29:0]}, {RESP_SLVERR, 30'h0});
      end
      final_report();
   end
endmodule
`default_nettype wire
